//--- src/pxb_pkg.sv
// Constants for the priority crossbar pin assigner
package pxb_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_SEL_FIRST = 8'he1;
  localparam logic [7:0] ADDR_SEL_SECOND = 8'he2;
  localparam logic [7:0] ADDR_SEL_THIRD = 8'he3;
  localparam logic [7:0] ADDR_SKIP0 = 8'hd4;
  localparam logic [7:0] ADDR_SKIP1 = 8'hd5;
  localparam logic [7:0] ADDR_SKIP2 = 8'hd6;
  localparam logic [7:0] ADDR_MDIN0 = 8'hf1;
  localparam logic [7:0] ADDR_MDIN1 = 8'hf2;
  localparam logic [7:0] ADDR_MDIN2 = 8'hf3;
  localparam logic [7:0] ADDR_MDOUT0 = 8'ha4;
  localparam logic [7:0] ADDR_MDOUT1 = 8'ha5;
  localparam logic [7:0] ADDR_MDOUT2 = 8'ha6;
  // Reset values
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_MDIN = 8'hff;
  localparam logic [7:0] RST_MDOUT = 8'h00;
  // Select-first fields
  localparam int B_CMP1_ASYNC = 7;
  localparam int B_CMP1_SYNC = 6;
  localparam int B_CMP0_ASYNC = 5;
  localparam int B_CMP0_SYNC = 4;
  localparam int B_CLKOUT = 3;
  localparam int B_SMBUS = 2;
  localparam int B_SPI = 1;
  localparam int B_SER0 = 0;
  // Select-second fields
  localparam int B_PULLUP_DIS = 7;
  localparam int B_XBAR_EN = 6;
  localparam int B_T1 = 5;
  localparam int B_T0 = 4;
  localparam int B_ECI = 3;
  localparam int B_CEX_HI = 2;
  // Select-third fields
  localparam int B_UART1 = 0;
  localparam logic [7:0] SEL_THIRD_MASK = 8'h03;
  // Pins
  localparam int NPIN = 24;
  localparam int LAST_CAND = 22;
  localparam int PIN_SER_TX = 4;
  localparam int PIN_SER_RX = 5;
  // Peripheral signal slots in priority order
  localparam int NSIG = 23;
  localparam int S_SER_TX = 0;
  localparam int S_SER_RX = 1;
  localparam int S_SCK = 2;
  localparam int S_MISO = 3;
  localparam int S_MOSI = 4;
  localparam int S_NSS = 5;
  localparam int S_SDA = 6;
  localparam int S_SCL = 7;
  localparam int S_CMP0 = 8;
  localparam int S_CMP0A = 9;
  localparam int S_CMP1 = 10;
  localparam int S_CMP1A = 11;
  localparam int S_CLKOUT = 12;
  localparam int S_CC0 = 13;
  localparam int S_ECI = 18;
  localparam int S_T0 = 19;
  localparam int S_T1 = 20;
  localparam int S_TX1 = 21;
  localparam int S_RX1 = 22;
  localparam int NCEX = 5;
  localparam logic [1:0] NSS_3WIRE = 2'h0;
endpackage

//--- src/pxb_crossbar.sv
// Priority crossbar that routes peripheral signals onto port pins
`timescale 1ns/10ps
module pxb_crossbar (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  // Peripheral side
  input wire logic [22:0] i_per_out,
  input wire logic [22:0] i_per_oe,
  output logic [22:0] o_per_in,
  input wire logic [1:0] i_spi_nss_mode,
  input wire logic i_output_clock_select,
  input wire logic i_system_clock_main,
  input wire logic i_system_clock_alt,
  // Port latch side
  input wire logic [23:0] i_gpio_out,
  output logic [23:0] o_gpio_in,
  // Pins
  input wire logic [23:0] i_pin_in,
  output logic [23:0] o_pin_out,
  output logic [23:0] o_pin_oe,
  output logic [23:0] o_pin_pullup,
  output logic [23:0] o_pin_rx_en
);
  logic [7:0] sel_first_r;
  logic [7:0] sel_second_r;
  logic [7:0] sel_third_r;
  logic [23:0] skip_r;
  logic [23:0] mdin_r;
  logic [23:0] mdout_r;
  logic [7:0] rdata_r;
  logic [23:0] sync1_r;
  logic [23:0] sync2_r;
  logic [23:0] sync3_r;
  logic [23:0] filt_r;
  logic [22:0] per_in_r;
  logic [23:0] gpio_in_r;
  logic [23:0] pin_out_r;
  logic [23:0] pin_oe_r;
  logic [23:0] pin_pu_r;
  logic [23:0] pin_rx_r;
  logic [22:0] sig_en;
  logic [22:0] per_val;
  logic [23:0] pin_asg;
  logic [4:0] pin_sig [24];
  logic [22:0] sig_placed;
  logic [4:0] sig_pin [23];
  logic [23:0] pin_out_nxt;
  logic [23:0] pin_oe_nxt;
  logic [23:0] pin_pu_nxt;
  logic [23:0] pin_rx_nxt;
  logic [22:0] per_in_nxt;
  logic [2:0] cex_code;
  logic xbar_en;
  logic pu_dis;

  assign xbar_en = sel_second_r[pxb_pkg::B_XBAR_EN];
  assign pu_dis = sel_second_r[pxb_pkg::B_PULLUP_DIS];
  assign cex_code = sel_second_r[pxb_pkg::B_CEX_HI:0];

  // Register writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_first_r <= pxb_pkg::RST_SEL;
      sel_second_r <= pxb_pkg::RST_SEL;
      sel_third_r <= pxb_pkg::RST_SEL;
      skip_r <= {3{pxb_pkg::RST_SKIP}};
      mdin_r <= {3{pxb_pkg::RST_MDIN}};
      mdout_r <= {3{pxb_pkg::RST_MDOUT}};
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == pxb_pkg::ADDR_SEL_FIRST) begin
        sel_first_r <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_SEL_SECOND) begin
        sel_second_r <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_SEL_THIRD) begin
        sel_third_r <= i_sfr_wdata & pxb_pkg::SEL_THIRD_MASK;
      end else if (i_sfr_addr == pxb_pkg::ADDR_SKIP0) begin
        skip_r[7:0] <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_SKIP1) begin
        skip_r[15:8] <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_SKIP2) begin
        skip_r[23:16] <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDIN0) begin
        mdin_r[7:0] <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDIN1) begin
        mdin_r[15:8] <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDIN2) begin
        mdin_r[23:16] <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDOUT0) begin
        mdout_r[7:0] <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDOUT1) begin
        mdout_r[15:8] <= i_sfr_wdata;
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDOUT2) begin
        mdout_r[23:16] <= i_sfr_wdata;
      end
    end
  end

  // Register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else if (i_sfr_rd) begin
      if (i_sfr_addr == pxb_pkg::ADDR_SEL_FIRST) begin
        rdata_r <= sel_first_r;
      end else if (i_sfr_addr == pxb_pkg::ADDR_SEL_SECOND) begin
        rdata_r <= sel_second_r;
      end else if (i_sfr_addr == pxb_pkg::ADDR_SEL_THIRD) begin
        rdata_r <= sel_third_r;
      end else if (i_sfr_addr == pxb_pkg::ADDR_SKIP0) begin
        rdata_r <= skip_r[7:0];
      end else if (i_sfr_addr == pxb_pkg::ADDR_SKIP1) begin
        rdata_r <= skip_r[15:8];
      end else if (i_sfr_addr == pxb_pkg::ADDR_SKIP2) begin
        rdata_r <= skip_r[23:16];
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDIN0) begin
        rdata_r <= mdin_r[7:0];
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDIN1) begin
        rdata_r <= mdin_r[15:8];
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDIN2) begin
        rdata_r <= mdin_r[23:16];
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDOUT0) begin
        rdata_r <= mdout_r[7:0];
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDOUT1) begin
        rdata_r <= mdout_r[15:8];
      end else if (i_sfr_addr == pxb_pkg::ADDR_MDOUT2) begin
        rdata_r <= mdout_r[23:16];
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // Which signal slots are requested
  always_comb begin
    sig_en = '0;
    sig_en[pxb_pkg::S_SER_TX] = sel_first_r[pxb_pkg::B_SER0];
    sig_en[pxb_pkg::S_SER_RX] = sel_first_r[pxb_pkg::B_SER0];
    sig_en[pxb_pkg::S_SCK] = sel_first_r[pxb_pkg::B_SPI];
    sig_en[pxb_pkg::S_MISO] = sel_first_r[pxb_pkg::B_SPI];
    sig_en[pxb_pkg::S_MOSI] = sel_first_r[pxb_pkg::B_SPI];
    sig_en[pxb_pkg::S_NSS] = sel_first_r[pxb_pkg::B_SPI] && (i_spi_nss_mode != pxb_pkg::NSS_3WIRE);
    sig_en[pxb_pkg::S_SDA] = sel_first_r[pxb_pkg::B_SMBUS];
    sig_en[pxb_pkg::S_SCL] = sel_first_r[pxb_pkg::B_SMBUS];
    sig_en[pxb_pkg::S_CMP0] = sel_first_r[pxb_pkg::B_CMP0_SYNC];
    sig_en[pxb_pkg::S_CMP0A] = sel_first_r[pxb_pkg::B_CMP0_ASYNC];
    sig_en[pxb_pkg::S_CMP1] = sel_first_r[pxb_pkg::B_CMP1_SYNC];
    sig_en[pxb_pkg::S_CMP1A] = sel_first_r[pxb_pkg::B_CMP1_ASYNC];
    sig_en[pxb_pkg::S_CLKOUT] = sel_first_r[pxb_pkg::B_CLKOUT];
    // Reserved codes 6 and 7 route nothing
    for (int c = 0; c < pxb_pkg::NCEX; c++) begin
      sig_en[pxb_pkg::S_CC0 + c] = (cex_code <= 3'h5) && (int'(cex_code) > c);
    end
    sig_en[pxb_pkg::S_ECI] = sel_second_r[pxb_pkg::B_ECI];
    sig_en[pxb_pkg::S_T0] = sel_second_r[pxb_pkg::B_T0];
    sig_en[pxb_pkg::S_T1] = sel_second_r[pxb_pkg::B_T1];
    sig_en[pxb_pkg::S_TX1] = sel_third_r[pxb_pkg::B_UART1];
    sig_en[pxb_pkg::S_RX1] = sel_third_r[pxb_pkg::B_UART1];
  end

  // Peripheral output values; clock slot carries the inverted chosen clock
  always_comb begin
    per_val = i_per_out;
    per_val[pxb_pkg::S_CLKOUT] = ~(i_output_clock_select ? i_system_clock_alt : i_system_clock_main);
  end

  // Priority allocation, rebuilt every cycle from the registers
  always_comb begin
    logic found;
    found = 1'b0;
    pin_asg = '0;
    sig_placed = '0;
    for (int p = 0; p < pxb_pkg::NPIN; p++) begin
      pin_sig[p] = 5'h00;
    end
    for (int s = 0; s < pxb_pkg::NSIG; s++) begin
      sig_pin[s] = 5'h00;
    end
    if (sig_en[pxb_pkg::S_SER_TX]) begin
      pin_asg[pxb_pkg::PIN_SER_TX] = 1'b1;
      pin_sig[pxb_pkg::PIN_SER_TX] = 5'(pxb_pkg::S_SER_TX);
      sig_pin[pxb_pkg::S_SER_TX] = 5'(pxb_pkg::PIN_SER_TX);
      sig_placed[pxb_pkg::S_SER_TX] = 1'b1;
      pin_asg[pxb_pkg::PIN_SER_RX] = 1'b1;
      pin_sig[pxb_pkg::PIN_SER_RX] = 5'(pxb_pkg::S_SER_RX);
      sig_pin[pxb_pkg::S_SER_RX] = 5'(pxb_pkg::PIN_SER_RX);
      sig_placed[pxb_pkg::S_SER_RX] = 1'b1;
    end
    for (int s = pxb_pkg::S_SCK; s < pxb_pkg::NSIG; s++) begin
      found = 1'b0;
      if (sig_en[s]) begin
        for (int p = 0; p <= pxb_pkg::LAST_CAND; p++) begin
          if (!found && !pin_asg[p] && !skip_r[p]) begin
            found = 1'b1;
            pin_asg[p] = 1'b1;
            pin_sig[p] = 5'(s);
            sig_pin[s] = 5'(p);
            sig_placed[s] = 1'b1;
          end
        end
      end
    end
  end

  // Per-pin drive, pullup and receiver
  always_comb begin
    logic val;
    logic drv;
    logic odrain;
    val = 1'b1;
    drv = 1'b0;
    odrain = 1'b0;
    pin_out_nxt = '0;
    pin_oe_nxt = '0;
    pin_pu_nxt = '0;
    pin_rx_nxt = '0;
    for (int p = 0; p < pxb_pkg::NPIN; p++) begin
      // Leftover pins fall back to the port latch
      val = pin_asg[p] ? per_val[pin_sig[p]] : i_gpio_out[p];
      drv = pin_asg[p] ? i_per_oe[pin_sig[p]] : 1'b1;
      odrain = !mdout_r[p] || (pin_asg[p] && (pin_sig[p] == 5'(pxb_pkg::S_SDA) ||
               pin_sig[p] == 5'(pxb_pkg::S_SCL)));
      if (!mdin_r[p]) begin
        pin_out_nxt[p] = 1'b0;
        pin_oe_nxt[p] = 1'b0;
        pin_pu_nxt[p] = 1'b0;
        pin_rx_nxt[p] = 1'b0;
      end else if (!xbar_en) begin
        pin_out_nxt[p] = 1'b0;
        pin_oe_nxt[p] = 1'b0;
        pin_pu_nxt[p] = !pu_dis;
        pin_rx_nxt[p] = 1'b1;
      end else if (odrain) begin
        pin_out_nxt[p] = 1'b0;
        pin_oe_nxt[p] = drv && !val;
        pin_pu_nxt[p] = !pu_dis && !(drv && !val);
        pin_rx_nxt[p] = 1'b1;
      end else begin
        pin_out_nxt[p] = val;
        pin_oe_nxt[p] = drv;
        pin_pu_nxt[p] = 1'b0;
        pin_rx_nxt[p] = 1'b1;
      end
    end
  end

  // Values handed back to peripherals; idle high when unplaced
  always_comb begin
    per_in_nxt = '1;
    for (int s = 0; s < pxb_pkg::NSIG; s++) begin
      if (xbar_en && sig_placed[s]) begin
        per_in_nxt[s] = filt_r[sig_pin[s]] && mdin_r[sig_pin[s]];
      end
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r <= '0;
    end else begin
      sync1_r <= i_pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int p = 0; p < pxb_pkg::NPIN; p++) begin
        if (sync2_r[p] == sync3_r[p]) begin
          filt_r[p] <= sync3_r[p];
        end
      end
    end
  end

  // Registered pin state; new settings land at the next edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
      pin_pu_r <= '1;
      pin_rx_r <= '1;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      pin_pu_r <= pin_pu_nxt;
      pin_rx_r <= pin_rx_nxt;
    end
  end

  // Readback to peripherals and port; analog pins read zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      per_in_r <= '1;
      gpio_in_r <= '0;
    end else begin
      per_in_r <= per_in_nxt;
      gpio_in_r <= filt_r & mdin_r;
    end
  end

  assign o_sfr_rdata = rdata_r;
  assign o_per_in = per_in_r;
  assign o_gpio_in = gpio_in_r;
  assign o_pin_out = pin_out_r;
  assign o_pin_oe = pin_oe_r;
  assign o_pin_pullup = pin_pu_r;
  assign o_pin_rx_en = pin_rx_r;
endmodule // pxb_crossbar

//--- sim/pxb_crossbar_properties.sv
// Port-level assertions for the priority crossbar
`timescale 1ns/10ps
module pxb_crossbar_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  // Peripheral side
  input wire logic [22:0] i_per_out,
  input wire logic [22:0] i_per_oe,
  input wire logic [22:0] o_per_in,
  // Pads
  input wire logic [23:0] o_pin_out,
  input wire logic [23:0] o_pin_oe,
  input wire logic [23:0] o_pin_pullup,
  input wire logic [23:0] o_pin_rx_en
);
  logic en_r;
  logic pd_r;
  logic u0_r;
  logic [23:0] md_r;
  logic tx_lo;
  // Shadow of the few register bits the checks depend on
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {pd_r, en_r, u0_r} <= 3'h0;
      md_r <= 24'hffffff;
    end else if (i_sfr_wr) begin
      case (i_sfr_addr)
        pxb_pkg::ADDR_SEL_FIRST: u0_r <= i_sfr_wdata[0];
        pxb_pkg::ADDR_SEL_SECOND: {pd_r, en_r} <= i_sfr_wdata[7:6];
        pxb_pkg::ADDR_MDIN0: md_r[7:0] <= i_sfr_wdata;
        pxb_pkg::ADDR_MDIN1: md_r[15:8] <= i_sfr_wdata;
        pxb_pkg::ADDR_MDIN2: md_r[23:16] <= i_sfr_wdata;
        default: ;
      endcase
    end
  end
  assign tx_lo = en_r && u0_r && md_r[4] && i_per_oe[0] && !i_per_out[0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  rst_vals_a: assert property ($past(i_rst) |-> o_pin_oe == 24'h0 && o_pin_rx_en == 24'hffffff
    && o_per_in == 23'h7fffff) else $error("pads not at reset values");
  sel_readback_a: assert property (i_sfr_wr && i_sfr_addr == pxb_pkg::ADDR_SEL_SECOND
    ##1 i_sfr_rd && !i_sfr_wr && i_sfr_addr == pxb_pkg::ADDR_SEL_SECOND
    |=> o_sfr_rdata == $past(i_sfr_wdata, 2)) else $error("second select readback wrong");
  xbar_off_a: assert property (!$past(en_r) |-> o_pin_oe == 24'h0)
    else $error("pad driven while crossbar off");
  per_in_off_a: assert property (!$past(en_r, 2) && !$past(en_r) |-> o_per_in == 23'h7fffff)
    else $error("peripheral input not idle while crossbar off");
  analog_pin_a: assert property ((~$past(md_r) & (o_pin_oe | o_pin_pullup | o_pin_rx_en)) == 24'h0)
    else $error("analog pin not isolated");
  low_drive_a: assert property ((o_pin_oe & ~o_pin_out & o_pin_pullup) == 24'h0)
    else $error("pullup on while driving low");
  pullup_dis_a: assert property ($past(pd_r) |-> o_pin_pullup == 24'h0)
    else $error("pullup on while globally disabled");
  uart_tx_a: assert property ($past(tx_lo) |-> o_pin_oe[4] && !o_pin_out[4])
    else $error("serial transmit not on pin 4");
endmodule // pxb_crossbar_properties

//--- sim/pxb_pad_model.sv
// Pad model: resolves each pin from pad controls and an outside driver
`timescale 1ns/10ps
module pxb_pad_model (
  // Clock
  input wire logic i_clk,
  // Pad controls and outside driver
  input wire logic [23:0] i_out,
  input wire logic [23:0] i_oe,
  input wire logic [23:0] i_pullup,
  input wire logic [23:0] i_ext,
  input wire logic [23:0] i_ext_en,
  // Resolved level
  output logic [23:0] o_level
);
  logic [23:0] float_r = 24'h555555;
  // Floating pads toggle so a stale level never passes as real
  always_ff @(posedge i_clk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int k = 0; k < 24; k++) begin
      if (i_oe[k]) o_level[k] = i_out[k];
      else if (i_ext_en[k]) o_level[k] = i_ext[k];
      else if (i_pullup[k]) o_level[k] = 1'b1;
      else o_level[k] = float_r[k];
    end
  end
endmodule // pxb_pad_model

//--- sim/pxb_crossbar_tb.sv
// Self-checking bench for the priority crossbar
`timescale 1ns/10ps
module pxb_crossbar_tb;
  typedef struct packed {
    logic [7:0] s0; logic [7:0] s1; logic [7:0] s2; logic [7:0] k0; logic [7:0] k2;
    logic [1:0] nss; logic [23:0] alloc;
  } pxb_row_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] o_sfr_rdata;
  logic [22:0] i_per_out = 23'h7fffff;
  logic [22:0] i_per_oe = 23'h0;
  logic [22:0] o_per_in;
  logic [1:0] i_spi_nss_mode = 2'h0;
  logic i_output_clock_select = 1'b0;
  logic i_system_clock_main = 1'b0;
  logic i_system_clock_alt = 1'b1;
  logic [23:0] i_gpio_out = 24'h0;
  logic [23:0] o_gpio_in, i_pin_in, o_pin_out, o_pin_oe, o_pin_pullup, o_pin_rx_en;
  logic [23:0] ext = 24'h0;
  logic [23:0] ext_en = 24'h0;
  int mismatches = 0;
  int samples_checked = 0;
  // Latch drives 0 everywhere, so free pins pull low and allocated pins stay undriven
  pxb_row_t rows [13] = '{
    '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 24'h000030},
    '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 24'h000007},
    '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 2'h1, 24'h00000f},
    '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 2'h2, 24'h00003f},
    '{8'h03, 8'h00, 8'h00, 8'h05, 8'h00, 2'h3, 24'h0000fa},
    '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 24'h000003},
    '{8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 24'h00000f},
    '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 2'h0, 24'h000001},
    '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 2'h0, 24'h00001f},
    '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 2'h0, 24'h000000},
    '{8'h01, 8'h00, 8'h00, 8'h30, 8'h00, 2'h0, 24'h000030},
    '{8'hf7, 8'h3d, 8'h01, 8'h01, 8'h00, 2'h1, 24'h7ffffe},
    '{8'hf7, 8'h3d, 8'h01, 8'h01, 8'h40, 2'h1, 24'h3ffffe}};
  pxb_crossbar DUT (.i_clk, .i_rst, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata,
    .i_per_out, .i_per_oe, .o_per_in, .i_spi_nss_mode, .i_output_clock_select, .i_system_clock_main,
    .i_system_clock_alt, .i_gpio_out, .o_gpio_in, .i_pin_in, .o_pin_out, .o_pin_oe, .o_pin_pullup, .o_pin_rx_en);
  pxb_pad_model u_pad (.i_clk, .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pullup(o_pin_pullup),
    .i_ext(ext), .i_ext_en(ext_en), .o_level(i_pin_in));
  always #2 i_clk = ~i_clk;
  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    samples_checked++;
    if (got !== want) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  endtask
  // Strobe stays high across back-to-back writes; caller drops it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_wr = 1'b1;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    @(negedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    i_sfr_rd = 1'b1;
    i_sfr_addr = a;
    @(negedge i_clk);
    chk(24'(o_sfr_rdata), 24'(want));
  endtask
  task automatic idle(input int n);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    repeat (n) @(negedge i_clk);
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    for (int n = 0; n < 13; n++) begin
      i_spi_nss_mode = rows[n].nss;
      wr(pxb_pkg::ADDR_SKIP0, rows[n].k0);
      wr(pxb_pkg::ADDR_SKIP2, rows[n].k2);
      wr(pxb_pkg::ADDR_SEL_FIRST, rows[n].s0);
      wr(pxb_pkg::ADDR_SEL_THIRD, rows[n].s2);
      wr(pxb_pkg::ADDR_SEL_SECOND, rows[n].s1 | 8'h40);
      idle(1);
      chk(o_pin_oe, ~rows[n].alloc);
      $display("row %0d done", n);
    end
    wr(pxb_pkg::ADDR_SEL_THIRD, 8'hff);
    wr(pxb_pkg::ADDR_SEL_SECOND, 8'h85);
    i_sfr_wr = 1'b0;
    rd(pxb_pkg::ADDR_SEL_SECOND, 8'h85);
    rd(pxb_pkg::ADDR_SEL_THIRD, 8'h03);
    rd(8'h00, 8'h00);
    idle(1);
    chk(o_pin_oe, 24'h0);
    chk(o_pin_pullup, 24'h0);
    chk(24'(o_per_in), 24'h7fffff);
    $display("test registers done");
    i_gpio_out = 24'hfffff0;
    wr(pxb_pkg::ADDR_MDIN0, 8'hfe);
    wr(pxb_pkg::ADDR_SEL_FIRST, 8'h00);
    wr(pxb_pkg::ADDR_SEL_THIRD, 8'h00);
    wr(pxb_pkg::ADDR_SEL_SECOND, 8'h40);
    idle(1);
    chk(o_pin_oe, 24'h00000e);
    chk(o_pin_pullup, 24'hfffff0);
    chk(o_pin_rx_en, 24'hfffffe);
    idle(6);
    chk(o_gpio_in, 24'hfffff0);
    wr(pxb_pkg::ADDR_MDOUT0, 8'hff);
    idle(1);
    chk(o_pin_oe, 24'h0000fe);
    chk(o_pin_pullup, 24'hffff00);
    $display("test pad modes done");
    i_per_oe = 23'h000041;
    i_per_out = 23'h7ffffe;
    wr(pxb_pkg::ADDR_SEL_FIRST, 8'h04);
    idle(1);
    chk(24'({o_pin_oe[2:1], o_pin_pullup[2:1]}), 24'h3);
    wr(pxb_pkg::ADDR_SEL_FIRST, 8'h01);
    ext_en = 24'h000020;
    idle(1);
    chk(24'({o_pin_oe[4], o_pin_out[4]}), 24'h2);
    idle(6);
    chk(24'(o_per_in[1]), 24'h0);
    wr(pxb_pkg::ADDR_SEL_FIRST, 8'h08);
    idle(1);
    chk(24'(o_pin_out[1]), 24'h1);
    i_output_clock_select = 1'b1;
    idle(1);
    chk(24'(o_pin_out[1]), 24'h0);
    $display("test routed signals done");
    i_rst = 1'b1;
    idle(2);
    chk(o_pin_oe | ~o_pin_pullup, 24'h0);
    i_rst = 1'b0;
    rd(pxb_pkg::ADDR_MDIN0, 8'hff);
    rd(pxb_pkg::ADDR_SEL_SECOND, 8'h00);
    rd(pxb_pkg::ADDR_SKIP0, 8'h00);
    idle(1);
    wr(pxb_pkg::ADDR_SKIP1, 8'h5a);
    wr(pxb_pkg::ADDR_MDIN1, 8'h3c);
    wr(pxb_pkg::ADDR_MDIN2, 8'hc3);
    wr(pxb_pkg::ADDR_MDOUT1, 8'h96);
    wr(pxb_pkg::ADDR_MDOUT2, 8'h69);
    i_sfr_wr = 1'b0;
    rd(pxb_pkg::ADDR_SKIP1, 8'h5a);
    rd(pxb_pkg::ADDR_MDIN1, 8'h3c);
    rd(pxb_pkg::ADDR_MDIN2, 8'hc3);
    rd(pxb_pkg::ADDR_MDOUT1, 8'h96);
    rd(pxb_pkg::ADDR_MDOUT2, 8'h69);
    idle(1);
    chk(o_pin_rx_en, 24'hc33cff);
    chk(o_pin_pullup, 24'hc33cff);
    $display("test reset done");
    stop_test();
  end
endmodule // pxb_crossbar_tb
bind pxb_crossbar pxb_crossbar_properties u_props (.i_clk, .i_rst, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr,
  .i_sfr_rd, .o_sfr_rdata, .i_per_out, .i_per_oe, .o_per_in, .o_pin_out, .o_pin_oe, .o_pin_pullup, .o_pin_rx_en);
